// ---- amp_sensor_config_map.svh ----
// Purpose: Offsets, field positions, reset values and masks of the amplifier configuration bank
// Assumes: 32-bit word registers, byte addresses as printed
// Notes:   Definitions only
`ifndef AMP_SENSOR_CONFIG_MAP_SVH
`define AMP_SENSOR_CONFIG_MAP_SVH

// Register byte addresses
`define AMP3_CHOP_OFS       32'h0000_0028
`define AMP2_CHOP_OFS       32'h0000_00a4
`define AMP3_CTRL_OFS       32'h0000_00d0
`define TEMP_ENABLE_OFS     32'h4006_9600

// Reset values
`define AMP3_CHOP_RESET     32'h0000_0001
`define AMP2_CHOP_RESET     32'h0000_0001
`define AMP3_CTRL_RESET     32'h0000_0011
`define TEMP_ENABLE_RESET   32'h0000_0002

// Writable bits; all others read as zero
`define CHOP_WMASK          32'h0000_0001
`define AMP3_CTRL_WMASK     32'h0000_7fff
`define TEMP_ENABLE_WMASK   32'h0000_0002

// Field positions
`define CHOP_DISABLE_BIT    0
`define SINK_BOOST_BIT      14
`define BIAS_SEL_MSB        12
`define BIAS_SEL_LSB        11
`define TIA_GAIN_MSB        10
`define TIA_GAIN_LSB        8
`define AMP_GAIN_MSB        7
`define AMP_GAIN_LSB        5
`define COUPLING_BIT        2
`define MODE_BIT            1
`define POWERDOWN_BIT       0
`define SENSOR_EN_BIT       1

// Select vector positions
`define SEL_AMP3_CHOP       0
`define SEL_AMP2_CHOP       1
`define SEL_AMP3_CTRL       2
`define SEL_TEMP_ENABLE     3

// Converter sample time factors
`define CHOP_SAMPLE_SCALE   2'h2
`define PLAIN_SAMPLE_SCALE  2'h1

`endif

// ---- amp_sensor_config_pkg.sv ----
// Purpose: Types and helpers of the amplifier configuration bank
// Assumes: Constants come from the map header
// Notes:   Shared by the bank and its register word
`include "amp_sensor_config_map.svh"

package amp_sensor_config_pkg;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b001,
    PH_WRITE = 3'b010,
    PH_READ  = 3'b100
  } bus_phase_t;

  typedef struct packed {
    logic       sink_boost_enable;
    logic [1:0] transimpedance_bias_select;
    logic [2:0] transimpedance_gain;
    logic [2:0] amp_gain;
    logic       coupling_select;
    logic       transimpedance_mode;
    logic       amp_core_powerdown;
  } amp3_cfg_t;

  typedef struct packed {
    logic bias_dac_ch11;
    logic bias_dac_ch10;
    logic bias_dac_ch9;
    logic bias_dac_ch8;
  } bias_route_t;

  typedef struct packed {
    logic [31:0] value;
  } word_state_t;

  // Writable bits take new data, the rest keep their value
  function automatic logic [31:0] merge_bits(input logic [31:0] old_value,
                                             input logic [31:0] new_value,
                                             input logic [31:0] mask);
    merge_bits = (old_value & ~mask) | (new_value & mask);
  endfunction

  function automatic logic [3:0] decode_addr(input logic [31:0] addr);
    decode_addr = 4'h0;
    case (addr)
      `AMP3_CHOP_OFS:   decode_addr[`SEL_AMP3_CHOP]   = 1'b1;
      `AMP2_CHOP_OFS:   decode_addr[`SEL_AMP2_CHOP]   = 1'b1;
      `AMP3_CTRL_OFS:   decode_addr[`SEL_AMP3_CTRL]   = 1'b1;
      `TEMP_ENABLE_OFS: decode_addr[`SEL_TEMP_ENABLE] = 1'b1;
      default:          decode_addr = 4'h0;
    endcase
  endfunction

  function automatic logic [1:0] sample_scale(input logic chop_disable);
    sample_scale = chop_disable ? `PLAIN_SAMPLE_SCALE : `CHOP_SAMPLE_SCALE;
  endfunction

endpackage

// ---- cfg_word.sv ----
// Purpose: One 32-bit configuration word with write mask
// Assumes: Write strobe lasts one enabled cycle
// Notes:   Bits outside the mask are held at zero
`timescale 1ns/1ps

module cfg_word
  import amp_sensor_config_pkg::*;
#(
  parameter logic [31:0] RESET_VALUE = 32'h0000_0000,
  parameter logic [31:0] WRITE_MASK  = 32'hffff_ffff
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // Write side
  input  wire logic        we,
  input  wire logic [31:0] wdata,
  // Contents
  output logic      [31:0] value,
  output logic      [31:0] next_value
);

  word_state_t state;
  word_state_t next_state;

  // Reset value may not set bits that writes cannot reach
  if ((RESET_VALUE & ~WRITE_MASK) != 32'h0000_0000) begin : g_bad_reset
    $error("Reset value sets read-only bits");
  end

  always_comb begin
    next_state = state;
    if (ce && we) begin
      next_state.value = merge_bits(state.value, wdata, WRITE_MASK);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '{value: RESET_VALUE};
    end else begin
      state <= next_state;
    end
  end

  assign value      = state.value;
  assign next_value = next_state.value;

endmodule

// ---- amp_sensor_config_regs.sv ----
// Purpose: AHB-Lite register bank steering the amplifier and sensor analog switches
// Assumes: Single slave, zero wait states while ce is high, word transfers only
// Notes:   Unmapped reads return zero, unmapped writes are dropped, response always OKAY
//
// Overview of operation
// - Second amplifier chop word holds a chop-disable bit at bit 0, reset 1, 0 turns chopping on.
// - Third amplifier chop word holds a chop-disable bit at bit 0, reset 1, 0 enables chopping.
// - With chopping on for a path, its converter sample time is reported as doubled.
// - Third amplifier control word sits at 0xd0 and resets to 0x11.
// - Control bit 14 turns on the current-sink boost in transimpedance mode, reset 0.
// - Control bits 12:11 pick bias channel eight to eleven in ascending order, reset 00.
// - Control bits 10:8 pick the feedback resistor code, reset 000.
// - Control bits 7:5 pick the amplifier gain code, reset 000.
// - Control bit 2 picks DC (0) or AC (1) coupling, reset 0.
// - Control bit 1 picks voltage-gain (0) or transimpedance (1) mode, reset 0.
// - Control bit 0 powers the core down while set and resets to 1.
// - Sensor enable word resets to 0x2, bit 1 enables the channel, other bits read-only.
`timescale 1ns/1ps

module amp_sensor_config_regs
  import amp_sensor_config_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Analog controls
  output logic             amp2_chop_disable,
  output logic             amp3_chop_disable,
  output amp3_cfg_t        amp3_cfg,
  output bias_route_t      bias_route,
  output logic             sensor_channel_enable,
  // Converter sample time factors
  output logic      [1:0]  amp2_sample_scale,
  output logic      [1:0]  amp3_sample_scale
);

  typedef struct packed {
    bus_phase_t  phase;
    logic [3:0]  wsel;
    logic [31:0] rdata;
    bias_route_t route;
    logic [1:0]  amp2_scale;
    logic [1:0]  amp3_scale;
  } ctl_state_t;

  ctl_state_t  state;
  ctl_state_t  next_state;
  logic [3:0]  we_vec;
  logic        accept;
  logic [31:0] amp3_chop_q;
  logic [31:0] amp2_chop_q;
  logic [31:0] amp3_ctrl_q;
  logic [31:0] temp_q;
  logic [31:0] amp3_chop_n;
  logic [31:0] amp2_chop_n;
  logic [31:0] amp3_ctrl_n;
  logic [31:0] temp_n;
  logic [31:0] read_mux;
  logic [3:0]  addr_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Register words

  cfg_word #(.RESET_VALUE(`AMP2_CHOP_RESET), .WRITE_MASK(`CHOP_WMASK)) u_amp2_chop (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (ce),
    .we         (we_vec[`SEL_AMP2_CHOP]),
    .wdata      (hwdata),
    .value      (amp2_chop_q),
    .next_value (amp2_chop_n)
  );

  cfg_word #(.RESET_VALUE(`AMP3_CHOP_RESET), .WRITE_MASK(`CHOP_WMASK)) u_amp3_chop (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (ce),
    .we         (we_vec[`SEL_AMP3_CHOP]),
    .wdata      (hwdata),
    .value      (amp3_chop_q),
    .next_value (amp3_chop_n)
  );

  // control word, spare bits 13 and 4:3 writable
  cfg_word #(.RESET_VALUE(`AMP3_CTRL_RESET), .WRITE_MASK(`AMP3_CTRL_WMASK)) u_amp3_ctrl (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (ce),
    .we         (we_vec[`SEL_AMP3_CTRL]),
    .wdata      (hwdata),
    .value      (amp3_ctrl_q),
    .next_value (amp3_ctrl_n)
  );

  // sensor word, only bit 1 writable
  cfg_word #(.RESET_VALUE(`TEMP_ENABLE_RESET), .WRITE_MASK(`TEMP_ENABLE_WMASK)) u_temp (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (ce),
    .we         (we_vec[`SEL_TEMP_ENABLE]),
    .wdata      (hwdata),
    .value      (temp_q),
    .next_value (temp_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign accept   = hsel && htrans[1] && hready && ce;
  assign addr_sel = decode_addr(haddr);

  // Write lands at the end of its data phase
  assign we_vec = (state.phase == PH_WRITE) ? state.wsel : 4'h0;

  // Next values, so a read right behind a write sees the new word
  always_comb begin
    read_mux = 32'h0000_0000;
    case (addr_sel)
      4'b0001: read_mux = amp3_chop_n;
      4'b0010: read_mux = amp2_chop_n;
      4'b0100: read_mux = amp3_ctrl_n;
      4'b1000: read_mux = temp_n;
      default: read_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control state

  always_comb begin
    next_state = state;
    if (ce) begin
      next_state.phase = PH_IDLE;
      next_state.wsel  = 4'h0;
      next_state.rdata = 32'h0000_0000;
      if (accept && hwrite) begin
        next_state.phase = PH_WRITE;
        next_state.wsel  = addr_sel;
      end else if (accept) begin
        next_state.phase = PH_READ;
        next_state.rdata = read_mux;
      end
      case (amp3_ctrl_n[`BIAS_SEL_MSB:`BIAS_SEL_LSB])
        2'h0:    next_state.route = 4'b0001;
        2'h1:    next_state.route = 4'b0010;
        2'h2:    next_state.route = 4'b0100;
        default: next_state.route = 4'b1000;
      endcase
      next_state.amp2_scale = sample_scale(amp2_chop_n[`CHOP_DISABLE_BIT]);
      next_state.amp3_scale = sample_scale(amp3_chop_n[`CHOP_DISABLE_BIT]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '{phase:      PH_IDLE,
                 wsel:       4'h0,
                 rdata:      32'h0000_0000,
                 route:      4'b0001,
                 amp2_scale: `PLAIN_SAMPLE_SCALE,
                 amp3_scale: `PLAIN_SAMPLE_SCALE};
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Stall the bus while the block is frozen
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = state.rdata;

  assign amp2_chop_disable = amp2_chop_q[`CHOP_DISABLE_BIT];
  assign amp3_chop_disable = amp3_chop_q[`CHOP_DISABLE_BIT];

  assign amp3_cfg.sink_boost_enable         = amp3_ctrl_q[`SINK_BOOST_BIT];
  assign amp3_cfg.transimpedance_bias_select = amp3_ctrl_q[`BIAS_SEL_MSB:`BIAS_SEL_LSB];
  assign amp3_cfg.transimpedance_gain       = amp3_ctrl_q[`TIA_GAIN_MSB:`TIA_GAIN_LSB];
  assign amp3_cfg.amp_gain                  = amp3_ctrl_q[`AMP_GAIN_MSB:`AMP_GAIN_LSB];
  assign amp3_cfg.coupling_select           = amp3_ctrl_q[`COUPLING_BIT];
  assign amp3_cfg.transimpedance_mode       = amp3_ctrl_q[`MODE_BIT];
  assign amp3_cfg.amp_core_powerdown        = amp3_ctrl_q[`POWERDOWN_BIT];

  assign bias_route            = state.route;
  assign sensor_channel_enable = temp_q[`SENSOR_EN_BIT];
  assign amp2_sample_scale     = state.amp2_scale;
  assign amp3_sample_scale     = state.amp3_scale;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_data_write(int idx);
    state.phase == PH_WRITE && state.wsel[idx] && ce;
  endsequence

  sequence s_addr_read(int idx);
    accept && !hwrite && addr_sel[idx];
  endsequence

  a_chop2_write: assert property (
    s_data_write(`SEL_AMP2_CHOP) |=> amp2_chop_disable == $past(hwdata[0])
  ) else $error("Chop word two did not take written bit");

  a_chop3_write: assert property (
    s_data_write(`SEL_AMP3_CHOP) |=> amp3_chop_disable == $past(hwdata[0]) ##1
      amp3_sample_scale == sample_scale(amp3_chop_disable) || !$past(ce)
  ) else $error("Chop word three or its sample factor wrong");

  a_sample_double: assert property (
    $rose(ce) or ce |-> amp2_sample_scale == (amp2_chop_disable ? 2'h1 : 2'h2)
  ) else $error("Sample time factor does not follow chop bit");

  a_ctrl_write: assert property (
    s_data_write(`SEL_AMP3_CTRL) |=> amp3_ctrl_q == ($past(hwdata) & `AMP3_CTRL_WMASK)
  ) else $error("Control word did not take written value");

  a_gain_fields: assert property (
    s_data_write(`SEL_AMP3_CTRL) |=> amp3_cfg.amp_gain == $past(hwdata[7:5])
      && amp3_cfg.transimpedance_gain == $past(hwdata[10:8])
      && amp3_cfg.sink_boost_enable == $past(hwdata[14])
  ) else $error("Gain or boost field mismatch");

  a_bias_route: assert property (
    ce |=> bias_route == (4'h1 << amp3_cfg.transimpedance_bias_select)
  ) else $error("Bias routing not one-hot on selected channel");

  a_ctrl_hold: assert property (
    !(state.phase == PH_WRITE && state.wsel[`SEL_AMP3_CTRL] && ce) |=> $stable(amp3_cfg)
  ) else $error("Control word changed without a write");

  a_sensor_read: assert property (
    s_addr_read(`SEL_TEMP_ENABLE) |=> hrdata == {30'h0, sensor_channel_enable, 1'b0}
  ) else $error("Sensor word read wrong");

  a_reserved_zero: assert property (
    amp3_ctrl_q[31:15] == 17'h0 && amp2_chop_q[31:1] == 31'h0
      && amp3_chop_q[31:1] == 31'h0
      && temp_q[0] == 1'b0 && temp_q[31:2] == 30'h0
  ) else $error("Read-only bits not zero");

  a_freeze_ce: assert property (
    !ce |=> $stable(state) && $stable(amp3_ctrl_q) && $stable(temp_q)
  ) else $error("State moved while clock enable low");

endmodule

// ---- amp_sensor_config_regs_tb_top.sv ----
// Purpose: Self-checking bench for the amplifier and sensor configuration bank
// Assumes: AHB-Lite single word transfers, hready fed back from hreadyout
// Notes:   Random stimulus from a fixed xorshift seed, shadow copy of every register
`timescale 1ns/1ps

module amp_sensor_config_regs_tb_top;
  import amp_sensor_config_pkg::*;

  // Clock, reset, enable
  logic        hclk;
  logic        hresetn;
  logic        ce;
  // Bus
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  // Analog controls
  logic        amp2_chop_disable;
  logic        amp3_chop_disable;
  amp3_cfg_t   amp3_cfg;
  bias_route_t bias_route;
  logic        sensor_channel_enable;
  logic [1:0]  amp2_sample_scale;
  logic [1:0]  amp3_sample_scale;
  // Bench state
  int          err_count;
  int          checks;
  logic [31:0] seed;
  logic [31:0] sh [5];
  logic [22:0] held;
  logic [31:0] adr [5]    = '{32'h0000_0028, 32'h0000_00a4, 32'h0000_00d0, 32'h4006_9600, 32'h4006_9604};
  logic [31:0] mask [5]   = '{32'h0000_0001, 32'h0000_0001, 32'h0000_7fff, 32'h0000_0002, 32'h0000_0000};
  logic [31:0] resetv [5] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0011, 32'h0000_0002, 32'h0000_0000};
  wire  [22:0] outs = {amp2_chop_disable, amp3_chop_disable, amp3_cfg, bias_route, sensor_channel_enable,
                       amp2_sample_scale, amp3_sample_scale};

  assign hready = hreadyout;

  amp_sensor_config_regs dut (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .ce                    (ce),
    .hsel                  (hsel),
    .haddr                 (haddr),
    .htrans                (htrans),
    .hwrite                (hwrite),
    .hsize                 (hsize),
    .hwdata                (hwdata),
    .hready                (hready),
    .hreadyout             (hreadyout),
    .hresp                 (hresp),
    .hrdata                (hrdata),
    .amp2_chop_disable     (amp2_chop_disable),
    .amp3_chop_disable     (amp3_chop_disable),
    .amp3_cfg              (amp3_cfg),
    .bias_route            (bias_route),
    .sensor_channel_enable (sensor_channel_enable),
    .amp2_sample_scale     (amp2_sample_scale),
    .amp3_sample_scale     (amp3_sample_scale)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Outputs expected from the shadow words
  function automatic logic [22:0] exp_outs(input logic [31:0] c2, input logic [31:0] c3,
                                           input logic [31:0] ctl, input logic [31:0] tmp);
    return {c2[0], c3[0], ctl[14], ctl[12:11], ctl[10:8], ctl[7:5], ctl[2], ctl[1], ctl[0],
            4'b0001 << ctl[12:11], tmp[1], c2[0] ? 2'h1 : 2'h2, c3[0] ? 2'h1 : 2'h2};
  endfunction

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_outs(input logic [22:0] got, input logic [22:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t controls got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // One single transfer, ready judged before each edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    logic rdy;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= a;
    hsize  <= 3'b010;
    do begin
      @(negedge hclk);
      rdy = hready;
      @(posedge hclk);
    end while (rdy !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    do begin
      @(negedge hclk);
      rdy = hready;
      rd  = hrdata;
      @(posedge hclk);
    end while (rdy !== 1'b1);
  endtask

  task automatic wr_reg(input int i, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, adr[i], d, rd);
    sh[i] = d & mask[i];
  endtask

  task automatic rd_check(input int i);
    logic [31:0] rd;
    bus(1'b0, adr[i], rnd(), rd);
    check_reg(rd, sh[i]);
  endtask

  task automatic verify_all();
    for (int i = 0; i < 5; i++) begin
      rd_check(i);
    end
    @(negedge hclk);
    check_outs(outs, exp_outs(sh[1], sh[0], sh[2], sh[3]));
  endtask

  task automatic do_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    htrans  <= 2'b00;
    hsel    <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      sh[i] = resetv[i];
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    err_count = 0;
    checks    = 0;
    seed      = 32'h0000_3efd;
    hsel      = 1'b0;
    haddr     = 32'h0000_0000;
    htrans    = 2'b00;
    hwrite    = 1'b0;
    hsize     = 3'b010;
    hwdata    = 32'h0000_0000;
    ce        = 1'b1;
    hresetn   = 1'b0;
    do_reset();
    verify_all();
    check_reg({31'h0, hresp}, 32'h0000_0000);
    // Every code of every control word field, random upper bits
    for (int k = 0; k < 8; k++) begin
      wr_reg(2, (rnd() & 32'hffff_a018) | (32'(k[0]) << 14) | (32'(k[1:0]) << 11) | (32'(k[2:0]) << 8)
             | (32'(7 - k) << 5) | 32'(k[2:0]));
      wr_reg(0, {rnd()} ^ 32'(k[0]));
      wr_reg(1, 32'hffff_fffe | 32'(k[1]));
      wr_reg(3, rnd());
      verify_all();
    end
    wr_reg(4, 32'hffff_ffff);
    verify_all();
    for (int n = 0; n < 40; n++) begin
      wr_reg(int'(rnd() % 5), rnd());
      verify_all();
    end
    // Frozen bus: address phase waits, controls hold
    held = outs;
    fork
      wr_reg(2, 32'h0000_6aa6);
      begin
        @(posedge hclk);
        ce <= 1'b0;
        repeat (4) begin
          @(negedge hclk);
          check_reg({31'h0, hreadyout}, 32'h0000_0000);
          check_outs(outs, held);
        end
        @(posedge hclk);
        ce <= 1'b1;
      end
    join
    verify_all();
    do_reset();
    verify_all();
    finish_test();
  end

endmodule
